//--- shared/dff_pkg.sv
// package: register map, field layout and timing constants of the fault flag block
package dff_pkg;
  // register indices (printed offsets not all multiples of four: byte address = 4 * index)
  localparam logic [7:0]  IDX_FLAGS      = 8'ha3;
  localparam logic [7:0]  IDX_RADIUS     = 8'ha5;
  localparam logic [7:0]  IDX_CTRL       = 8'ha6;
  localparam logic [7:0]  IDX_FILT       = 8'ha7;
  localparam logic [7:0]  IDX_MARGIN     = 8'ha8;
  localparam logic [11:0] ADDR_FLAGS     = {2'h0, IDX_FLAGS, 2'h0};
  localparam logic [11:0] ADDR_RADIUS    = {2'h0, IDX_RADIUS, 2'h0};
  localparam logic [11:0] ADDR_CTRL      = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_FILT      = {2'h0, IDX_FILT, 2'h0};
  localparam logic [11:0] ADDR_MARGIN    = {2'h0, IDX_MARGIN, 2'h0};
  // flag bit positions
  localparam int B_ACF  = 0;
  localparam int B_AOC  = 1;
  localparam int B_TMP  = 2;
  localparam int B_SAT  = 3;
  localparam int B_SLF  = 4;
  localparam int B_RAD  = 5;
  localparam int B_PON  = 6;
  localparam int B_MSB  = 7;
  localparam int B_UV   = 8;
  localparam int B_OV   = 9;
  localparam int B_MMB  = 10;
  localparam int B_SHP  = 11;
  localparam int B_OSC  = 12;
  localparam int NFLAGS = 13;
  // critical flags, cleared only by reset; bits 11 and 12 are also cleared by their mask bits in ctrl
  localparam logic [12:0] CRIT_MASK = 13'h1c00;
  // flag register reset: power-on flag set
  localparam logic [12:0] FLAGS_RESET = 13'h0040;
  // mask register reset: lin_all_a (bit 13) and path_all_a (bit 14) set
  localparam logic [31:0] CTRL_RESET = 32'h0000_6000;
  localparam int C_LINSAT  = 13;
  localparam int C_PATHSAT = 14;
  localparam int C_ANGTH   = 15;
  localparam int C_GAINSAT = 16;
  localparam int C_OFFSAT  = 17;
  localparam int C_FMINEN  = 18;
  localparam int C_FMAXEN  = 19;
  localparam logic [31:0] FILT_RESET = 32'h0000_0000;
  localparam int PERIODIC_UPD = 10;
  localparam int AOC_FILT_MAX = 16;
  localparam int RAD_FILT_MAX = 8;
  localparam int FILT_SATURATION_MAX = 16;
  localparam int OSC_TOL_PCT  = 20;
  // margin test select
  typedef enum logic [1:0] {DFF_MARG_ONES, DFF_MARG_ZEROS, DFF_MARG_BOTH} dff_marg_t;
  // raw condition inputs grouped
  typedef struct packed {
    logic analog_check_bad;
    logic temp_sat;
    logic lin_saturation;
    logic filt_saturation;
    logic trim_fact_sat;
    logic trim_cust_sat;
    logic gain_sat;
    logic offset_sat;
    logic selftest_mismatch;
    logic latency_miss;
    logic under_voltage;
    logic over_voltage;
    logic mem_single_bit;
    logic mem_multi_bit;
    logic shadow_parity;
  } dff_cond_t;
endpackage : dff_pkg

//--- src/dff_flags.sv
// fault flag register bank with apb access
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dff_flags
  import dff_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // signal path
  input  wire logic        ANGLE_UPDATE,
  input  wire logic [15:0] ANGLE,
  input  wire logic [15:0] CLAMP_UPPER,
  input  wire logic [15:0] CLAMP_LOWER,
  input  wire logic [15:0] PREGAIN_ANGLE,
  input  wire logic [15:0] ANGLE_THRESH_LOW,
  input  wire logic [15:0] ANGLE_THRESH_HIGH,
  input  wire logic signed [15:0] CHAN_A,
  input  wire logic signed [15:0] CHAN_B,
  input  wire logic [7:0]  FIELD_MIN,
  input  wire logic [8:0]  FIELD_MAX,
  input  wire dff_cond_t   COND,
  // oscillator watchdog counts per window
  input  wire logic [15:0] OSC_MAIN_COUNT,
  input  wire logic [15:0] OSC_WDOG_COUNT,
  // output protocol report
  input  wire logic        REPORT,
  input  wire logic [12:0] REPORT_BITS,
  input  wire logic        FIRST_MSG,
  // margin test
  input  wire logic        CUST_ACCESS,
  input  wire logic        MARGIN_DONE,
  input  wire logic [1:0]  MARGIN_FAIL,
  output logic             MARGIN_START,
  output dff_marg_t        MARGIN_SEL,
  // status
  output logic [12:0]      FLAGS,
  output logic             DIAG_STATE,
  output logic             FIRST_MSG_PON
);
  logic [12:0] flags_reg;
  logic [12:0] flags_next;
  logic [12:0] cond_now;
  logic [31:0] ctrl_reg;
  logic [31:0] filt_reg;
  logic [16:0] radius_sq_reg;
  logic [3:0]  period_cnt_reg;
  logic        first_upd_reg;
  logic [3:0]  margin_res_reg;
  logic [31:0] prdata_next;
  logic        acc;
  logic        rd_flags;
  logic        periodic;
  logic [12:0] mask_vec;
  logic [4:0]  aoc_lim;
  logic [4:0]  sat_lim;
  logic [3:0]  rad_lim;
  logic        aoc_raw;
  logic        sat_raw;
  logic        path_saturation;
  logic        rad_raw;
  logic [8:0]  a_s;
  logic [8:0]  b_s;
  logic [16:0] rsq;
  logic        osc_bad;
  logic [4:0]  aoc_cnt_reg;
  logic [4:0]  sat_cnt_reg;
  logic [3:0]  rad_cnt_reg;

  assign acc      = PSEL & PENABLE;
  assign rd_flags = acc & ~PWRITE & (PADDR == ADDR_FLAGS);
  assign periodic = ANGLE_UPDATE & (period_cnt_reg == 4'(PERIODIC_UPD - 1));
  assign PREADY   = 1'b1;
  assign aoc_lim  = {1'b0, filt_reg[3:0]} + 5'h01;
  assign sat_lim  = {1'b0, filt_reg[7:4]} + 5'h01;
  assign rad_lim  = {1'b0, filt_reg[10:8]} + 4'h1;

  // mask bits at flag positions of ctrl
  assign mask_vec = {ctrl_reg[12:11], 1'b0, ctrl_reg[9:0]};

  assign aoc_raw = (ANGLE >= CLAMP_UPPER) | (ANGLE <= CLAMP_LOWER);
  assign path_saturation = COND.trim_fact_sat | COND.trim_cust_sat
    | (ctrl_reg[C_ANGTH] & ((PREGAIN_ANGLE < ANGLE_THRESH_LOW) | (PREGAIN_ANGLE > ANGLE_THRESH_HIGH)))
    | (ctrl_reg[C_GAINSAT] & COND.gain_sat)
    | (ctrl_reg[C_OFFSAT] & COND.offset_sat);
  assign sat_raw = (COND.lin_saturation & ~ctrl_reg[C_LINSAT]) | COND.filt_saturation
    | (path_saturation & ~ctrl_reg[C_PATHSAT]);

  // radius from floor(chan/128)
  assign a_s = 9'(CHAN_A >>> 7);
  assign b_s = 9'(CHAN_B >>> 7);
  assign rsq = 17'($signed(a_s) * $signed(a_s)) + 17'($signed(b_s) * $signed(b_s));
  assign rad_raw = (ctrl_reg[C_FMINEN] & (rsq <= 17'(FIELD_MIN * FIELD_MIN)))
    | (ctrl_reg[C_FMAXEN] & ({1'b0, rsq} >= 18'(FIELD_MAX * FIELD_MAX)));

  // oscillator ratio outside 20 percent
  assign osc_bad = ({8'h00, OSC_MAIN_COUNT} * 24'h000064 > {8'h00, OSC_WDOG_COUNT} * 24'(100 + OSC_TOL_PCT))
    | ({8'h00, OSC_MAIN_COUNT} * 24'h000064 < {8'h00, OSC_WDOG_COUNT} * 24'(100 - OSC_TOL_PCT));

  // update period counter
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      period_cnt_reg <= 4'h0;
    end else if (ANGLE_UPDATE) begin
      period_cnt_reg <= periodic ? 4'h0 : period_cnt_reg + 4'h1;
    end
  end

  // fault filters: consecutive faulty updates
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      aoc_cnt_reg <= 5'h00;
      sat_cnt_reg <= 5'h00;
      rad_cnt_reg <= 4'h0;
    end else if (ANGLE_UPDATE) begin
      aoc_cnt_reg <= !aoc_raw ? 5'h00 : (aoc_cnt_reg < aoc_lim ? aoc_cnt_reg + 5'h01 : aoc_cnt_reg);
      sat_cnt_reg <= !sat_raw ? 5'h00 : (sat_cnt_reg < sat_lim ? sat_cnt_reg + 5'h01 : sat_cnt_reg);
      rad_cnt_reg <= !rad_raw ? 4'h0 : (rad_cnt_reg < rad_lim ? rad_cnt_reg + 4'h1 : rad_cnt_reg);
    end
  end

  // conditions present this cycle
  always_comb begin
    cond_now = '0;
    cond_now[B_ACF] = COND.analog_check_bad;
    cond_now[B_AOC] = ANGLE_UPDATE & aoc_raw & (aoc_cnt_reg + 5'h01 >= aoc_lim);
    cond_now[B_TMP] = COND.temp_sat;
    cond_now[B_SAT] = ANGLE_UPDATE & sat_raw & (sat_cnt_reg + 5'h01 >= sat_lim);
    cond_now[B_SLF] = periodic & (COND.selftest_mismatch | COND.latency_miss);
    cond_now[B_RAD] = ANGLE_UPDATE & rad_raw & (rad_cnt_reg + 4'h1 >= rad_lim);
    cond_now[B_PON] = ~first_upd_reg;
    cond_now[B_MSB] = COND.mem_single_bit;
    cond_now[B_UV]  = COND.under_voltage;
    cond_now[B_OV]  = COND.over_voltage;
    cond_now[B_MMB] = COND.mem_multi_bit;
    cond_now[B_SHP] = periodic & COND.shadow_parity;
    cond_now[B_OSC] = periodic & osc_bad;
  end

  // flag update: set wins, critical stay until reset (bits 11 and 12 also cleared by their mask bits)
  always_comb begin
    flags_next = flags_reg;
    if (rd_flags) begin
      flags_next = flags_reg & CRIT_MASK;
    end
    if (REPORT) begin
      flags_next = flags_next & ~(REPORT_BITS & ~CRIT_MASK);
    end
    flags_next = (flags_next | cond_now) & ~mask_vec;
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      flags_reg <= FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      first_upd_reg <= 1'b0;
    end else if (ANGLE_UPDATE) begin
      first_upd_reg <= 1'b1;
    end
  end

  // radius snapshot
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      radius_sq_reg <= 17'h00000;
    end else if (ANGLE_UPDATE) begin
      radius_sq_reg <= rsq;
    end
  end

  // writable registers
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ctrl_reg <= CTRL_RESET;
      filt_reg <= FILT_RESET;
    end else if (acc & PWRITE) begin
      if (PADDR == ADDR_CTRL) ctrl_reg <= PWDATA;
      if (PADDR == ADDR_FILT) filt_reg <= PWDATA;
    end
  end

  // margin test control and results
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      MARGIN_START   <= 1'b0;
      MARGIN_SEL     <= DFF_MARG_ONES;
      margin_res_reg <= 4'h0;
    end else begin
      MARGIN_START <= acc & PWRITE & (PADDR == ADDR_MARGIN) & CUST_ACCESS & PWDATA[2];
      if (acc & PWRITE & (PADDR == ADDR_MARGIN) & CUST_ACCESS) begin
        MARGIN_SEL <= (PWDATA[1:0] == 2'h1) ? DFF_MARG_ZEROS : (PWDATA[1:0] == 2'h2) ? DFF_MARG_BOTH : DFF_MARG_ONES;
      end
      if (MARGIN_DONE) begin
        margin_res_reg <= {1'b1, 1'b0, MARGIN_FAIL};
      end
    end
  end

  // read mux
  always_comb begin
    case (PADDR)
      ADDR_FLAGS:  prdata_next = {19'h0, flags_reg};
      ADDR_RADIUS: prdata_next = {15'h0, radius_sq_reg};
      ADDR_CTRL:   prdata_next = ctrl_reg;
      ADDR_FILT:   prdata_next = filt_reg;
      ADDR_MARGIN: prdata_next = {26'h0, margin_res_reg, MARGIN_SEL};
      default:     prdata_next = 32'h0;
    endcase
  end

  assign PRDATA  = prdata_next;
  assign PSLVERR = acc & ~((PADDR == ADDR_FLAGS) | (PADDR == ADDR_RADIUS) | (PADDR == ADDR_CTRL)
    | (PADDR == ADDR_FILT) | (PADDR == ADDR_MARGIN) | (PADDR == ADDR_FLAGS)) | (acc & PWRITE
    & ((PADDR == ADDR_FLAGS) | (PADDR == ADDR_RADIUS)));

  assign FLAGS         = flags_reg;
  assign DIAG_STATE    = |(flags_reg & ~(13'(1) << B_PON));
  assign FIRST_MSG_PON = FIRST_MSG & flags_reg[B_PON];

  AST_CRIT_STICKY: assert property (@(posedge MCLK) disable iff (RESET)
    flags_reg[B_MMB] |=> flags_reg[B_MMB]) else $error("multi-bit flag dropped");
  AST_OSC_STICKY: assert property (@(posedge MCLK) disable iff (RESET)
    flags_reg[B_OSC] && !ctrl_reg[B_OSC] |=> flags_reg[B_OSC]) else $error("osc flag dropped");
  AST_HIGH_ZERO: assert property (@(posedge MCLK) disable iff (RESET)
    rd_flags |-> PRDATA[31:13] == 19'h0) else $error("upper flag bits nonzero");
  AST_CLEAR_ON_READ: assert property (@(posedge MCLK) disable iff (RESET)
    rd_flags && !cond_now[B_TMP] && !REPORT |=> !flags_reg[B_TMP]) else $error("temp flag not cleared");
  AST_KEEP_IF_PRESENT: assert property (@(posedge MCLK) disable iff (RESET)
    cond_now[B_ACF] && !ctrl_reg[B_ACF] |=> flags_reg[B_ACF]) else $error("present fault lost");
  AST_MASK_ACF: assert property (@(posedge MCLK) disable iff (RESET)
    ctrl_reg[B_ACF] |=> !flags_reg[B_ACF] || !$past(ctrl_reg[B_ACF])) else $error("masked flag set");
  AST_PON_HOLD: assert property (@(posedge MCLK) disable iff (RESET)
    !first_upd_reg && !ctrl_reg[B_PON] |=> flags_reg[B_PON]) else $error("power-on flag cleared early");
  AST_PERIOD: assert property (@(posedge MCLK) disable iff (RESET)
    period_cnt_reg < 4'(PERIODIC_UPD)) else $error("period counter overrun");
  AST_MARGIN_DIAG: assert property (@(posedge MCLK) disable iff (RESET)
    MARGIN_DONE && flags_reg == 13'h0 |=> !DIAG_STATE || cond_now != 13'h0 || $past(cond_now) != 13'h0)
    else $error("margin drove diagnostic");
  COV_READ_CLEAR: cover property (@(posedge MCLK) disable iff (RESET) rd_flags && flags_reg[B_TMP]);
  COV_SAT: cover property (@(posedge MCLK) disable iff (RESET) cond_now[B_SAT]);
  COV_RAD: cover property (@(posedge MCLK) disable iff (RESET) cond_now[B_RAD]);
  COV_REPORT: cover property (@(posedge MCLK) disable iff (RESET) REPORT && |REPORT_BITS);
endmodule : dff_flags
`default_nettype wire

//--- dv/dff_host.sv
// partner model: apb host and output protocol report source
`timescale 1ns/1ps
`default_nettype none
module dff_host
  import dff_pkg::*;
(
  // clock and slave answer
  input  wire logic   mclk,
  input  wire logic   pready,
  // apb request
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // output protocol
  output logic        report,
  output logic [12:0] report_bits,
  output logic        first_msg
);
  logic [65:0] exp_q[$];
  initial begin
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0000_0000;
    report      = 1'b0;
    report_bits = 13'h0000;
    first_msg   = 1'b0;
  end
  // one transfer, expected answer noted first
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e, input logic [32:0] m);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    exp_q.push_back({m, e});
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
  // report of sent flags by the output encoder
  task automatic send(input logic [12:0] bits);
    @(posedge mclk);
    report      <= 1'b1;
    report_bits <= bits;
    @(posedge mclk);
    report      <= 1'b0;
    report_bits <= ~bits;
  endtask : send
endmodule : dff_host
`default_nettype wire

//--- dv/diagnostic_fault_flag_logic_test.sv
// self-checking bench of the fault flag block
`timescale 1ns/1ps
`default_nettype none
module diagnostic_fault_flag_logic_test
  import dff_pkg::*;
;
  logic mclk = 1'b0, reset = 1'b1, upd = 1'b0, cust = 1'b1, mdone = 1'b0;
  logic [15:0] angle = 16'h8000, ocnt = 16'h0064, owd = 16'h0064;
  logic signed [15:0] cha = 16'sh0500, chb = 16'sh0000;
  logic [7:0]  fmin = 8'h00;
  logic [8:0]  fmax = 9'h1ff;
  logic [1:0]  mfail = 2'h0;
  dff_cond_t   cond = '0;
  logic psel, pen, pwr, prdy, perr, rep, fmsg, diag, fpon, mst;
  dff_marg_t   msel;
  logic [11:0] padr;
  logic [31:0] pwd, prd;
  logic [12:0] rbits, flg;
  int err_total = 0, cmp_count = 0, cyc = 0;
  int ci[5] = '{14, 13, 4, 3, 2};
  int fb[5] = '{B_ACF, B_TMP, B_UV, B_OV, B_MSB};
  logic [65:0] ent;
  always #12.5 mclk = ~mclk;
  dff_host u_dff_host (.mclk(mclk), .pready(prdy), .psel(psel), .penable(pen), .pwrite(pwr), .paddr(padr),
    .pwdata(pwd), .report(rep), .report_bits(rbits), .first_msg(fmsg));
  dff_flags u_dff_flags (.MCLK(mclk), .RESET(reset), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .ANGLE_UPDATE(upd), .ANGLE(angle),
    .CLAMP_UPPER(16'hffff), .CLAMP_LOWER(16'h0000), .PREGAIN_ANGLE(angle), .ANGLE_THRESH_LOW(16'h0000),
    .ANGLE_THRESH_HIGH(16'hffff), .CHAN_A(cha), .CHAN_B(chb), .FIELD_MIN(fmin), .FIELD_MAX(fmax),
    .COND(cond), .OSC_MAIN_COUNT(ocnt), .OSC_WDOG_COUNT(owd), .REPORT(rep), .REPORT_BITS(rbits),
    .FIRST_MSG(fmsg), .CUST_ACCESS(cust), .MARGIN_DONE(mdone), .MARGIN_FAIL(mfail), .MARGIN_START(mst),
    .MARGIN_SEL(msel), .FLAGS(flg), .DIAG_STATE(diag), .FIRST_MSG_PON(fpon));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // monitor: each completed transfer answers the oldest note
  always @(posedge mclk) begin
    cyc++;
    if (psel && pen && prdy) begin
      ent = u_dff_host.exp_q.pop_front();
      check({perr, prd} & ent[65:33], ent[32:0] & ent[65:33]);
    end
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    u_dff_host.xfer(1'b0, a, 32'h0, {1'b0, e}, {1'b1, 32'hffff_ffff});
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_dff_host.xfer(1'b1, a, d, 33'h0, 33'h1_0000_0000);
  endtask : wr
  task automatic upds(input int n);
    repeat (n) begin
      @(posedge mclk) upd <= 1'b1;
      @(posedge mclk) upd <= 1'b0;
    end
  endtask : upds
  task automatic gone(input int b);
    rd(ADDR_FLAGS, 32'h1 << b);
    rd(ADDR_FLAGS, 32'h0);
  endtask : gone
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial begin
    logic [31:0] r;
    void'($urandom(32'h51c8));
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    u_dff_host.first_msg <= 1'b1;
    rd(ADDR_FLAGS, 32'h40);
    check(fpon, 1'b1);
    rd(ADDR_CTRL, CTRL_RESET);
    u_dff_host.xfer(1'b0, 12'h000, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
    u_dff_host.xfer(1'b1, ADDR_FLAGS, 32'h1fff, 33'h1_0000_0000, 33'h1_0000_0000);
    upds(1);
    gone(B_PON);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      cond[ci[i]] <= 1'b1;
      rd(ADDR_FLAGS, 32'h1 << fb[i]);
      rd(ADDR_FLAGS, 32'h1 << fb[i]);
      check(diag, 1'b1);
      cond <= '0;
      gone(fb[i]);
    end
    cond.analog_check_bad <= 1'b1;
    rd(ADDR_FLAGS, 32'h1);
    cond <= '0;
    u_dff_host.send(13'h0001);
    rd(ADDR_FLAGS, 32'h0);
    wr(ADDR_CTRL, CTRL_RESET | 32'h1);
    cond.analog_check_bad <= 1'b1;
    rd(ADDR_FLAGS, 32'h0);
    check(diag, 1'b0);
    cond <= '0;
    wr(ADDR_CTRL, CTRL_RESET);
    $display("test noncritical done");
    wr(ADDR_FILT, 32'h2);
    angle <= 16'hffff;
    upds(2);
    rd(ADDR_FLAGS, 32'h0);
    upds(1);
    angle <= 16'h8000;
    gone(B_AOC);
    angle <= 16'h0000;
    upds(3);
    angle <= 16'h8000;
    gone(B_AOC);
    cond.filt_saturation <= 1'b1;
    cond.lin_saturation <= 1'b1;
    upds(2);
    cond <= '0;
    gone(B_SAT);
    cond.lin_saturation <= 1'b1;
    upds(2);
    cond <= '0;
    rd(ADDR_FLAGS, 32'h0);
    wr(ADDR_CTRL, (CTRL_RESET & ~(32'h1 << C_PATHSAT)) | (32'h1 << C_GAINSAT));
    cond.gain_sat <= 1'b1;
    upds(1);
    cond <= '0;
    wr(ADDR_CTRL, CTRL_RESET);
    gone(B_SAT);
    $display("test filter done");
    repeat (3) begin
      cha <= 16'(($urandom & 32'h7fff));
      chb <= 16'(($urandom & 32'h7fff));
      upds(1);
      r = ((32'(cha) >> 7) * (32'(cha) >> 7)) + ((32'(chb) >> 7) * (32'(chb) >> 7));
      rd(ADDR_RADIUS, r);
    end
    cha <= 16'sh0500;
    chb <= 16'sh0000;
    fmin <= 8'h14;
    wr(ADDR_CTRL, CTRL_RESET | (32'h1 << C_FMINEN));
    upds(1);
    wr(ADDR_CTRL, CTRL_RESET);
    gone(B_RAD);
    chb <= 16'sh0500;
    fmax <= 9'h00e;
    wr(ADDR_CTRL, CTRL_RESET | (32'h1 << C_FMAXEN));
    upds(1);
    wr(ADDR_CTRL, CTRL_RESET);
    gone(B_RAD);
    $display("test radius done");
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_MARGIN, 32'h4 | s);
      @(posedge mclk) check(mst, 1'b1);
      check(33'(msel), 33'(s));
      rd(ADDR_MARGIN, s);
    end
    cust <= 1'b0;
    wr(ADDR_MARGIN, 32'h4);
    @(posedge mclk) check(mst, 1'b0);
    rd(ADDR_MARGIN, 32'h2);
    cust <= 1'b1;
    mfail <= 2'h3;
    @(posedge mclk) mdone <= 1'b1;
    @(posedge mclk) mdone <= 1'b0;
    rd(ADDR_MARGIN, 32'h2e);
    check(diag, 1'b0);
    $display("test margin done");
    cond.mem_multi_bit <= 1'b1;
    cond.selftest_mismatch <= 1'b1;
    ocnt <= 16'h0082;
    upds(10);
    cond <= '0;
    ocnt <= 16'h0064;
    @(posedge mclk) check(flg, 13'h1410);
    rd(ADDR_FLAGS, 32'h1410);
    rd(ADDR_FLAGS, 32'h1400);
    check(diag, 1'b1);
    @(posedge mclk) reset <= 1'b1;
    @(posedge mclk) reset <= 1'b0;
    rd(ADDR_FLAGS, 32'h40);
    $display("test critical done");
    repeat (4) @(posedge mclk);
    results();
  end
endmodule : diagnostic_fault_flag_logic_test
`default_nettype wire
